// ---- aisc_ctrl.sv ----
// Purpose: input and reference select control for a 10-bit converter
// Assumes: conversion engine supplies busy and a done pulse with results
// Notes: writes during a conversion are held until its done pulse
//
// Operation
// - the temperature code routes the sensor as a single-ended input and enables it.
// - reference codes 00 supply, 01 external pin, 10 internal 1.1V, 11 internal driven onto the pin.
// - reference code 11 drives the internal reference onto the external pin.
// - a reference change during a conversion applies once that conversion is done.
// - a channel change during a conversion applies once that conversion is done.
// - codes 0..7 select pins, 100000 ground, 100001 internal reference.
// - codes group into differential, reversed differential and calibration ranges.
// - the lowest bit picks 1x or 20x gain on differential selections.
// - the top bit swaps positive and negative on normal pairs.
// - calibration ties one pin to both inputs, for inputs zero, three and seven.
// - each pair and gain code decodes per the pair table.
// - the done flag sets when a conversion finishes and results are updated.
//
// Local design decision: the Wishbone register port.
`default_nettype none
module aisc_ctrl (
   input wire logic clk_sys_i,                 // system clock, 50 MHz
   input wire logic rst_n_i,                   // async reset, active low
   input wire logic wb_cyc_i,                  // wishbone cycle
   input wire logic wb_stb_i,                  // wishbone strobe
   input wire logic wb_we_i,                   // wishbone write
   input wire logic [7:0] wb_adr_i,            // wishbone byte address
   input wire logic [3:0] wb_sel_i,            // wishbone byte select
   input wire logic [31:0] wb_dat_i,           // wishbone write data
   output logic [31:0] wb_dat_o,               // wishbone read data
   output logic wb_ack_o,                      // wishbone ack
   output logic wb_err_o,                      // wishbone error
   input wire logic conv_busy_i,               // conversion running
   input wire logic conv_done_i,               // conversion end, results stored
   output logic irq_o,                         // level interrupt
   output aisc_pkg::aisc_route_t route_o,      // applied channel routing
   output aisc_pkg::aisc_ref_t ref_o,          // applied reference switches
   output logic [7:0] applied_sel_o            // applied selection value
);
   // ==========================================
   // bus decode
   wire logic req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   wire logic hit_sel = (wb_adr_i == aisc_pkg::ADDR_SEL);
   wire logic hit_stat = (wb_adr_i == aisc_pkg::ADDR_STAT);
   wire logic hit_irq = (wb_adr_i == aisc_pkg::ADDR_IRQ);
   wire logic hit_mask = (wb_adr_i == aisc_pkg::ADDR_MASK);
   wire logic hit_any = hit_sel | hit_stat | hit_irq | hit_mask;
   wire logic wr_lane0 = req && wb_we_i && wb_sel_i[0];
   wire logic wr_sel = wr_lane0 && hit_sel;
   wire logic wr_irq = wr_lane0 && hit_irq;
   wire logic wr_mask = wr_lane0 && hit_mask;

   // ==========================================
   // registers
   logic [7:0] sel_reg;
   logic [7:0] applied_reg;
   logic pend_reg;
   logic [1:0] irq_reg;
   logic [1:0] mask_reg;
   logic [31:0] rdat_reg;
   logic ack_reg;
   logic err_reg;

   wire logic [7:0] sel_next = wr_sel ? wb_dat_i[7:0] : sel_reg;
   wire logic commit_now = !conv_busy_i || conv_done_i;
   wire logic differs = (sel_next != applied_reg);
   wire logic [7:0] applied_next = commit_now ? sel_next : applied_reg;
   wire logic pend_next = !commit_now && differs;
   // deferred update applied at done
   wire logic apply_evt = pend_reg && commit_now && conv_done_i;

   wire logic [1:0] irq_evt = {apply_evt, conv_done_i};
   wire logic [1:0] irq_clr = wr_irq ? wb_dat_i[1:0] : 2'h0;
   // set wins over clear
   wire logic [1:0] irq_next = (irq_reg & ~irq_clr) | irq_evt;
   wire logic [1:0] mask_next = wr_mask ? wb_dat_i[1:0] : mask_reg;

   wire logic [31:0] rd_mux =
      hit_sel  ? {24'h00_0000, sel_reg} :
      hit_stat ? {14'h0000, pend_reg, conv_busy_i, 8'h00, applied_reg} :
      hit_irq  ? {30'h0000_0000, irq_reg} :
      hit_mask ? {30'h0000_0000, mask_reg} : 32'h0000_0000;

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sel_reg <= aisc_pkg::SEL_RESET;
         applied_reg <= aisc_pkg::SEL_RESET;
         pend_reg <= 1'b0;
      end else begin
         sel_reg <= sel_next;
         applied_reg <= applied_next;
         pend_reg <= pend_next;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_reg <= aisc_pkg::IRQ_RESET;
         mask_reg <= aisc_pkg::IRQ_RESET;
      end else begin
         irq_reg <= irq_next;
         mask_reg <= mask_next;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ack_reg <= 1'b0;
         err_reg <= 1'b0;
         rdat_reg <= 32'h0000_0000;
      end else begin
         ack_reg <= req && hit_any;
         err_reg <= req && !hit_any;
         rdat_reg <= (req && !wb_we_i) ? rd_mux : 32'h0000_0000;
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_err_o = err_reg;
   assign wb_dat_o = rdat_reg;
   assign irq_o = |(irq_reg & mask_reg);
   assign applied_sel_o = applied_reg;

   // ==========================================
   // decoders on the applied value
   aisc_mux_decode u_mux (
      .code_i (applied_reg[5:0]),
      .route_o (route_o)
   );

   aisc_ref_decode u_ref (
      .code_i (applied_reg[7:6]),
      .ref_o (ref_o)
   );
endmodule : aisc_ctrl
`default_nettype wire

// ---- aisc_pkg.sv ----
// Purpose: shared constants and types for the converter input select control
// Assumes: classic wishbone register access, 32-bit data, one clock
// Notes: register offsets are byte addresses (index times four)
`default_nettype none
package aisc_pkg;
   // ==========================================
   // register map
   localparam logic [7:0] SEL_IDX = 8'h07;
   localparam logic [7:0] ADDR_SEL = 8'h1C;
   localparam logic [7:0] ADDR_STAT = 8'h20;
   localparam logic [7:0] ADDR_IRQ = 8'h24;
   localparam logic [7:0] ADDR_MASK = 8'h28;
   localparam logic [7:0] SEL_RESET = 8'h00;
   localparam logic [1:0] IRQ_RESET = 2'h0;
   // irq bit positions
   localparam int IRQ_DONE = 0;
   localparam int IRQ_APPLY = 1;
   // ==========================================
   // reference codes
   localparam logic [1:0] REF_SUPPLY = 2'h0;
   localparam logic [1:0] REF_EXT = 2'h1;
   localparam logic [1:0] REF_INT = 2'h2;
   localparam logic [1:0] REF_INT_OUT = 2'h3;
   // ==========================================
   // channel codes
   localparam logic [5:0] CH_GND = 6'h20;
   localparam logic [5:0] CH_IREF = 6'h21;
   localparam logic [5:0] CH_TEMP = 6'h22;
   localparam logic [5:0] CH_CAL_LO = 6'h23;
   localparam logic [5:0] CH_CAL_HI = 6'h27;
   localparam logic [5:0] CH_DIFF_LO = 6'h08;
   localparam logic [5:0] CH_REV_LO = 6'h28;
   // source kinds
   typedef enum logic [2:0] {
      AISC_SRC_PIN = 3'b000,
      AISC_SRC_GND = 3'b001,
      AISC_SRC_IREF = 3'b010,
      AISC_SRC_TEMP = 3'b011,
      AISC_SRC_DIFF = 3'b100,
      AISC_SRC_NONE = 3'b101
   } aisc_src_t;
   // decoded routing
   typedef struct packed {
      aisc_src_t kind;
      logic [2:0] pos_pin;
      logic [2:0] neg_pin;
      logic gain_x20;
      logic temp_en;
   } aisc_route_t;
   typedef struct packed {
      logic supply_ref;
      logic ext_ref_in;
      logic int_ref_on;
      logic int_ref_to_pin;
   } aisc_ref_t;
endpackage : aisc_pkg
`default_nettype wire

// ---- aisc_mux_decode.sv ----
// Purpose: decode a channel select field into a routing set
// Assumes: code applied is already the committed one
// Notes: combinational; undefined differential codes route nothing
`default_nettype none
module aisc_mux_decode (
   input wire logic [5:0] code_i,              // channel select field
   output aisc_pkg::aisc_route_t route_o       // decoded routing
);
   // ==========================================
   // pair table, indexed by code[5:1], or by {0, code[4:1]} for reversed codes
   function automatic logic [6:0] pair_lookup(input logic [4:0] idx);
      // {valid, pos, neg}
      unique case (idx)
         5'h04: pair_lookup = {1'b1, 3'd0, 3'd1};
         5'h05: pair_lookup = {1'b1, 3'd0, 3'd3};
         5'h06: pair_lookup = {1'b1, 3'd1, 3'd2};
         5'h07: pair_lookup = {1'b1, 3'd1, 3'd3};
         5'h08: pair_lookup = {1'b1, 3'd2, 3'd3};
         5'h09: pair_lookup = {1'b1, 3'd3, 3'd4};
         5'h0A: pair_lookup = {1'b1, 3'd3, 3'd5};
         5'h0B: pair_lookup = {1'b1, 3'd3, 3'd6};
         5'h0C: pair_lookup = {1'b1, 3'd3, 3'd7};
         5'h0D: pair_lookup = {1'b1, 3'd4, 3'd5};
         5'h0E: pair_lookup = {1'b1, 3'd5, 3'd6};
         5'h0F: pair_lookup = {1'b1, 3'd6, 3'd7};
         5'h11: pair_lookup = {1'b1, 3'd0, 3'd0};
         5'h12: pair_lookup = {1'b1, 3'd3, 3'd3};
         5'h13: pair_lookup = {1'b1, 3'd7, 3'd7};
         default: pair_lookup = 7'h00;
      endcase
   endfunction : pair_lookup

   wire logic is_pin = (code_i < aisc_pkg::CH_DIFF_LO);
   wire logic is_rev = (code_i >= aisc_pkg::CH_REV_LO);
   wire logic [4:0] pair_idx = is_rev ? {1'b0, code_i[4:1]} : code_i[5:1];
   wire logic [6:0] pair = pair_lookup(pair_idx);
   // input zero 1x slot is the sensor code, decoded first
   wire logic diff_ok = pair[6];

   always_comb begin
      route_o = '0;
      route_o.kind = aisc_pkg::AISC_SRC_NONE;
      if (is_pin) begin
         route_o.kind = aisc_pkg::AISC_SRC_PIN;
         route_o.pos_pin = code_i[2:0];
      end else if (code_i == aisc_pkg::CH_GND) begin
         route_o.kind = aisc_pkg::AISC_SRC_GND;
      end else if (code_i == aisc_pkg::CH_IREF) begin
         route_o.kind = aisc_pkg::AISC_SRC_IREF;
      end else if (code_i == aisc_pkg::CH_TEMP) begin
         route_o.kind = aisc_pkg::AISC_SRC_TEMP;
         route_o.temp_en = 1'b1;
      end else if (diff_ok) begin
         route_o.kind = aisc_pkg::AISC_SRC_DIFF;
         route_o.pos_pin = is_rev ? pair[2:0] : pair[5:3];
         route_o.neg_pin = is_rev ? pair[5:3] : pair[2:0];
         route_o.gain_x20 = code_i[0];
      end
   end
endmodule : aisc_mux_decode
`default_nettype wire

// ---- aisc_ref_decode.sv ----
// Purpose: decode the reference select field into reference switches
// Assumes: field is the committed one
// Notes: combinational
`default_nettype none
module aisc_ref_decode (
   input wire logic [1:0] code_i,              // reference select field
   output aisc_pkg::aisc_ref_t ref_o           // reference switches
);
   wire logic sel_sup = (code_i == aisc_pkg::REF_SUPPLY);
   wire logic sel_ext = (code_i == aisc_pkg::REF_EXT);
   wire logic sel_int = (code_i == aisc_pkg::REF_INT);
   wire logic sel_out = (code_i == aisc_pkg::REF_INT_OUT);
   // one driver for the whole struct: supply, ext in, int on, int to pin
   assign ref_o = {sel_sup, sel_ext, sel_int | sel_out, sel_out};
endmodule : aisc_ref_decode
`default_nettype wire

// ---- aisc_ctrl_chk.sv ----
// Purpose: port checker for aisc_ctrl
// Assumes: one clock, async active-low reset
// Notes: bound to every aisc_ctrl
`default_nettype none
module aisc_ctrl_chk (
   input wire logic clk_sys_i, // clock
   input wire logic rst_n_i, // reset
   input wire logic wb_cyc_i, // cycle
   input wire logic wb_stb_i, // strobe
   input wire logic wb_we_i, // write
   input wire logic conv_busy_i, // busy
   input wire logic conv_done_i, // done
   input wire aisc_pkg::aisc_route_t route_o, // routing
   input wire aisc_pkg::aisc_ref_t ref_o, // reference
   input wire logic [7:0] applied_sel_o // applied
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   // ==========================================
   // decode
   property p_temp;
      applied_sel_o[5:0] == 6'h22 |-> route_o.kind == aisc_pkg::AISC_SRC_TEMP && route_o.temp_en;
   endproperty
   a_temp: assert property (p_temp) else $error("temp route wrong");
   property p_gnd;
      applied_sel_o[5:0] == 6'h20 |-> route_o.kind == aisc_pkg::AISC_SRC_GND;
   endproperty
   a_gnd: assert property (p_gnd) else $error("ground route wrong");
   property p_ext;
      applied_sel_o[7:6] == 2'h1 |-> ref_o.ext_ref_in && !ref_o.int_ref_on;
   endproperty
   a_ext: assert property (p_ext) else $error("external ref wrong");
   property p_pin;
      applied_sel_o[7:6] == 2'h3 |-> ref_o.int_ref_to_pin && !ref_o.ext_ref_in;
   endproperty
   a_pin: assert property (p_pin) else $error("ref to pin wrong");
   property p_gain;
      route_o.kind == aisc_pkg::AISC_SRC_DIFF |-> route_o.gain_x20 == applied_sel_o[0];
   endproperty
   a_gain: assert property (p_gain) else $error("gain bit wrong");
   property p_cal;
      applied_sel_o[5:0] == 6'h26 |-> route_o.pos_pin == 3'h7 && route_o.neg_pin == 3'h7;
   endproperty
   a_cal: assert property (p_cal) else $error("calibration pins wrong");
   // ==========================================
   // deferral
   property p_hold;
      conv_busy_i && !conv_done_i |=> $stable(applied_sel_o);
   endproperty
   a_hold: assert property (p_hold) else $error("applied during busy");
   property p_cause;
      $changed(applied_sel_o) |-> $past(conv_done_i) || $past(wb_cyc_i && wb_stb_i && wb_we_i);
   endproperty
   a_cause: assert property (p_cause) else $error("applied without cause");
endmodule : aisc_ctrl_chk
bind aisc_ctrl aisc_ctrl_chk u_chk (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .conv_busy_i(conv_busy_i),
   .conv_done_i(conv_done_i), .route_o(route_o), .ref_o(ref_o),
   .applied_sel_o(applied_sel_o));
`default_nettype wire

// ---- tb_aisc_ctrl.sv ----
// Purpose: self-checking bench for aisc_ctrl
// Assumes: 50 MHz clock, classic wishbone master
// Notes: selection table, then bus refusals, deferral, irq and reset
`default_nettype none
module tb_aisc_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [7:0] sel;
      logic [10:0] r_exp;
      logic [10:0] r_msk;
      logic [3:0] f_exp;
      logic [3:0] f_msk;
   } aisc_row_t;
   logic clk_sys_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic busy = 1'b0;
   logic done = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] dat = 32'h0000_0000;
   logic [31:0] rdat;
   logic [31:0] q;
   logic ack, err, irq, e;
   aisc_pkg::aisc_route_t route;
   aisc_pkg::aisc_ref_t refs;
   logic [7:0] appl;
   int n_mismatch = 0;
   int comparisons = 0;
   aisc_row_t rows [14] = '{'{8'h00, 11'h000, 11'h7E1, 4'h8, 4'hF},
      '{8'h47, 11'h0E0, 11'h7E1, 4'h4, 4'hF}, '{8'hA0, 11'h100, 11'h701, 4'h2, 4'hF},
      '{8'h21, 11'h200, 11'h701, 4'h8, 4'hF}, '{8'hA2, 11'h301, 11'h701, 4'h2, 4'hF},
      '{8'h09, 11'h406, 11'h7FF, 4'h8, 4'hF}, '{8'h28, 11'h420, 11'h7FF, 4'h8, 4'hF},
      '{8'h23, 11'h402, 11'h7FF, 4'h8, 4'hF}, '{8'h26, 11'h4FC, 11'h7FF, 4'h8, 4'hF},
      '{8'h3F, 11'h4FA, 11'h7FF, 4'h8, 4'hF}, '{8'h10, 11'h44C, 11'h7FF, 4'h8, 4'hF},
      '{8'h25, 11'h46E, 11'h7FF, 4'h8, 4'hF}, '{8'h2C, 11'h444, 11'h7FF, 4'h8, 4'hF},
      '{8'hC0, 11'h000, 11'h7E1, 4'h1, 4'h5}};
   always #10 clk_sys_i = ~clk_sys_i;
   aisc_ctrl dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .wb_err_o(err), .conv_busy_i(busy), .conv_done_i(done),
      .irq_o(irq), .route_o(route), .ref_o(refs), .applied_sel_o(appl));
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : give_verdict
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      comparisons++;
      if (got !== ex) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, ex, got);
      end
   endtask : chk
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
      int n;
      n = 0;
      @(posedge clk_sys_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= {24'h00_0000, d};
      sel <= s;
      @(posedge clk_sys_i);
      while (ack !== 1'b1 && err !== 1'b1 && n < 20) begin
         @(posedge clk_sys_i);
         n++;
      end
      if (n == 20) begin
         n_mismatch++;
         give_verdict();
      end else begin
         q = rdat;
         e = err;
         cyc <= 1'b0;
         stb <= 1'b0;
      end
   endtask : wb
   initial begin
      repeat (12) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      wb(1'b0, aisc_pkg::ADDR_SEL, 8'h00, 4'hF);
      chk("sel reset", 32'h0000_0000, q);
      chk("ref reset", 32'h0000_0008, refs);
      foreach (rows[i]) begin
         wb(1'b1, aisc_pkg::ADDR_SEL, rows[i].sel, 4'h1);
         chk("applied", rows[i].sel, appl);
         chk("route", rows[i].r_exp, route & rows[i].r_msk);
         chk("ref", rows[i].f_exp, refs & rows[i].f_msk);
      end
      wb(1'b1, aisc_pkg::ADDR_SEL, 8'h47, 4'h2);
      chk("lane ignored", 32'h0000_00C0, appl);
      wb(1'b0, 8'h30, 8'h00, 4'hF);
      chk("unmapped err", 32'h0000_0001, e);
      busy <= 1'b1;
      wb(1'b1, aisc_pkg::ADDR_SEL, 8'hA2, 4'h1);
      chk("held", 32'h0000_00C0, appl);
      chk("ref held", 32'h0000_0003, refs);
      wb(1'b0, aisc_pkg::ADDR_STAT, 8'h00, 4'hF);
      chk("status", 32'h0003_00C0, q);
      @(posedge clk_sys_i);
      chk("still held", 32'h0000_00C0, appl);
      done <= 1'b1;
      @(posedge clk_sys_i);
      done <= 1'b0;
      busy <= 1'b0;
      @(posedge clk_sys_i);
      chk("commit", 32'h0000_00A2, appl);
      chk("ref commit", 32'h0000_0002, refs);
      chk("temp route", 32'h0000_0301, route & 11'h701);
      chk("masked irq", 32'h0000_0000, irq);
      wb(1'b0, aisc_pkg::ADDR_IRQ, 8'h00, 4'hF);
      chk("irq status", 32'h0000_0003, q);
      wb(1'b1, aisc_pkg::ADDR_MASK, 8'h03, 4'h1);
      chk("irq on", 32'h0000_0001, irq);
      wb(1'b1, aisc_pkg::ADDR_IRQ, 8'h03, 4'h1);
      chk("irq off", 32'h0000_0000, irq);
      // reset again mid-run, held over two edges
      rst_n_i <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      chk("rst applied", 32'h0000_0000, appl);
      chk("rst route", 32'h0000_0000, route);
      chk("rst ref", 32'h0000_0008, refs);
      chk("rst irq", 32'h0000_0000, irq);
      rst_n_i <= 1'b1;
      wb(1'b0, aisc_pkg::ADDR_MASK, 8'h00, 4'hF);
      chk("rst mask", 32'h0000_0000, q);
      wb(1'b0, aisc_pkg::ADDR_SEL, 8'h00, 4'hF);
      chk("rst sel", 32'h0000_0000, q);
      give_verdict();
   end
endmodule : tb_aisc_ctrl
`default_nettype wire
